// File: rtl/rpm_defines.svh
`ifndef RPM_DEFINES_SVH
`define RPM_DEFINES_SVH

// power control register address on the special function bus
`define RPM_PWR_CTL_ADDR 8'h87

// field positions inside the power control register
`define RPM_BAUD_DBL_BIT 7
`define RPM_FE_SEL_BIT 6
`define RPM_RSVD_BIT 5
`define RPM_PWR_ON_BIT 4
`define RPM_USER1_BIT 3
`define RPM_USER0_BIT 2
`define RPM_DEEP_BIT 1
`define RPM_LIGHT_BIT 0

// reset value of the software fields
`define RPM_PWR_CTL_RESET 8'h00

// timing counts, in oscillator clock periods
`define RPM_POR_CYCLES 1024
`define RPM_WDOG_PULSE_CYCLES 96
`define RPM_KBD_WAKE_CYCLES 1024

`endif

// File: rtl/rpm_pkg.sv
package rpm_pkg;

  // reset sources seen by the sequencer
  typedef struct packed {
    logic supply_ok;    // internal supply above safety level
    logic osc_ok;       // oscillator input is toggling
    logic rst_pin_n;    // level read back from the reset pin
    logic hw_wdog_ovf;  // hardware watchdog overflow pulse
    logic ca_wdog_rst;  // counter-array watchdog reset request
  } rpm_rst_src_t;

  // wake-up sources, keyboard and usb already enable-gated
  typedef struct packed {
    logic ext_irq_zero_n;  // external interrupt pin zero, active low
    logic ext_irq_one_n;   // external interrupt pin one, active low
    logic ext_zero_en;     // pin zero interrupt enabled
    logic ext_one_en;      // pin one interrupt enabled
    logic kbd_irq;         // enabled keyboard interrupt
    logic usb_irq;         // enabled usb interrupt
    logic any_irq;         // any enabled interrupt pending
  } rpm_wake_t;

  // special function register access from the cpu
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } rpm_sfr_req_t;

  // low-power state machine, gray along run-idle-pd-wake
  typedef enum logic [2:0] {
    RPM_RUN = 3'h0,
    RPM_IDLE = 3'h1,
    RPM_PD = 3'h3,
    RPM_PD_EXT = 3'h2,
    RPM_PD_KBD = 3'h6
  } rpm_state_t;

endpackage

// File: rtl/rpm_count.sv
`timescale 1ns/1ps
// saturating cycle counter, done after LIMIT running edges
module rpm_count #(
  parameter int LIMIT = 96
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_clear,
  input wire logic i_run,
  // status
  output logic o_done
);
  localparam int W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LIM = W'(LIMIT);

  logic [W-1:0] cnt_r;  // elapsed running edges
  logic [W-1:0] cnt_nxt;
  logic done_r;  // count reached the limit
  logic done_nxt;

  // clear wins, then count until saturated
  assign cnt_nxt = i_clear ? '0 : ((i_run && !done_r) ? cnt_r + 1'b1 : cnt_r);
  assign done_nxt = !i_clear && (cnt_nxt == LIM);

  // state registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign o_done = done_r;
endmodule

// File: rtl/rpm_top.sv
`timescale 1ns/1ps
`include "rpm_defines.svh"
module rpm_top
  import rpm_pkg::*;
#(
  parameter int POR_CYCLES = `RPM_POR_CYCLES,
  parameter int WDOG_PULSE_CYCLES = `RPM_WDOG_PULSE_CYCLES,
  parameter int KBD_WAKE_CYCLES = `RPM_KBD_WAKE_CYCLES
) (
  // clock and block reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // reset sources
  input wire rpm_rst_src_t i_rst_src,
  // wake-up sources
  input wire rpm_wake_t i_wake,
  // special function register access
  input wire rpm_sfr_req_t i_sfr,
  output logic [7:0] o_sfr_rdata,
  // serial control top bit sources
  input wire logic i_framing_error_bit,
  input wire logic i_serial_mode_high_bit,
  output logic o_serial_ctl_top_bit,
  output logic o_baud_doubler,
  // reset outputs
  output logic o_sys_rst,
  output logic o_rst_pin_n_out,
  output logic o_rst_pin_n_oe,
  // clock gating
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en,
  output logic o_osc_en,
  // pin behaviour while sleeping
  output logic o_port_hold,
  output logic o_strobe_hold,
  output logic o_strobe_level,
  output logic o_port0_low_only,
  // low-power exit by interrupt, one cycle
  output logic o_lp_exit
);

  // ---------------- reset combination ----------------

  logic por_done;  // power-up count complete
  logic wd_act_r;  // watchdog pulse in progress
  logic wd_act_nxt;
  logic wd_done;  // watchdog pulse count complete
  logic sys_rst_r;  // combined internal reset
  logic sys_rst_nxt;
  logic pin_oe_r;  // driving the reset pin
  logic pin_oe_nxt;
  logic pin_out_r;  // level driven on the reset pin
  wire pwr_good = i_rst_src.supply_ok && i_rst_src.osc_ok;

  // power-up delay restarts whenever supply or oscillator is lost
  rpm_count #(
    .LIMIT(POR_CYCLES)
  ) u_por_cnt (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clear(!pwr_good),
    .i_run(1'b1),
    .o_done(por_done)
  );

  // watchdog pulse length counter, idle while no pulse runs
  rpm_count #(
    .LIMIT(WDOG_PULSE_CYCLES)
  ) u_wd_cnt (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clear(!wd_act_r),
    .i_run(1'b1),
    .o_done(wd_done)
  );

  // start on overflow, stop once the count completes
  assign wd_act_nxt = wd_act_r ? !wd_done : i_rst_src.hw_wdog_ovf;
  // pin driven low for exactly the counted window
  assign pin_oe_nxt = wd_act_r && !wd_done;

  // all sources ored; supply loss bypasses the counter
  assign sys_rst_nxt = !i_rst_src.supply_ok
                     || !por_done
                     || !i_rst_src.rst_pin_n
                     || i_rst_src.ca_wdog_rst
                     || wd_act_r;

  // reset registers, released on a clock edge
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sys_rst_r <= 1'b1;
      wd_act_r <= 1'b0;
      pin_oe_r <= 1'b0;
      pin_out_r <= 1'b0;
    end else begin
      sys_rst_r <= sys_rst_nxt;
      wd_act_r <= wd_act_nxt;
      pin_oe_r <= pin_oe_nxt;
      pin_out_r <= 1'b0;  // pin only ever pulled low
    end
  end

  // ---------------- power control register ----------------

  logic [7:0] power_control_r;  // stored register fields
  logic [7:0] power_control_nxt;
  logic [7:0] power_control_view;  // read view with reserved bit
  logic supply_prev_r;  // supply level one cycle ago
  logic lp_clear;  // interrupt exit clears sleep bits
  logic [7:0] rdata_q;  // registered read data
  logic [7:0] rdata_nxt;
  wire wr_hit = i_sfr.wr && (i_sfr.addr == `RPM_PWR_CTL_ADDR);
  wire rd_hit = i_sfr.rd && (i_sfr.addr == `RPM_PWR_CTL_ADDR);
  wire pof_set = i_rst_src.supply_ok && !supply_prev_r;  // supply came up

  // next value of each field
  always_comb begin
    power_control_nxt = power_control_r;
    if (wr_hit) begin
      power_control_nxt = i_sfr.wdata;
    end
    power_control_nxt[`RPM_RSVD_BIT] = 1'b0;
    if (lp_clear) begin
      power_control_nxt[`RPM_DEEP_BIT] = 1'b0;
      power_control_nxt[`RPM_LIGHT_BIT] = 1'b0;
    end
    if (sys_rst_r) begin
      // reset redefines the fields, the power-on flag survives
      power_control_nxt = `RPM_PWR_CTL_RESET;
      power_control_nxt[`RPM_PWR_ON_BIT] = power_control_r[`RPM_PWR_ON_BIT];
    end
    if (pof_set) begin
      power_control_nxt[`RPM_PWR_ON_BIT] = 1'b1;
    end
  end

  // read view: reserved bit forced to zero
  assign power_control_view = {power_control_r[7:6], 1'b0, power_control_r[4:0]};
  assign rdata_nxt = rd_hit ? power_control_view : 8'h00;

  // register storage and registered read data
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      power_control_r <= `RPM_PWR_CTL_RESET;
      supply_prev_r <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      power_control_r <= power_control_nxt;
      supply_prev_r <= i_rst_src.supply_ok;
      rdata_q <= rdata_nxt;
    end
  end

  // ---------------- low-power state machine ----------------

  rpm_state_t state_r;  // current power mode
  rpm_state_t state_nxt;
  logic [1:0] held_r;  // external pins that woke the oscillator
  logic [1:0] held_nxt;
  logic kbd_done;  // keyboard wake delay complete
  wire deep_req = power_control_r[`RPM_DEEP_BIT];
  wire light_req = power_control_r[`RPM_LIGHT_BIT];
  wire [1:0] ext_low = {i_wake.ext_one_en && !i_wake.ext_irq_one_n,
                        i_wake.ext_zero_en && !i_wake.ext_irq_zero_n};
  wire [1:0] ext_rel = held_r & ~ext_low;  // held pin released

  // keyboard wake delay runs only in its own state
  rpm_count #(
    .LIMIT(KBD_WAKE_CYCLES)
  ) u_kbd_cnt (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clear(state_r != RPM_PD_KBD),
    .i_run(1'b1),
    .o_done(kbd_done)
  );

  // mode transitions
  always_comb begin
    state_nxt = state_r;
    held_nxt = held_r;
    lp_clear = 1'b0;
    unique case (state_r)
      RPM_RUN: begin
        // power-down takes priority when both bits are set
        if (deep_req) begin
          state_nxt = RPM_PD;
        end else if (light_req) begin
          state_nxt = RPM_IDLE;
        end
      end
      RPM_IDLE: begin
        // any enabled interrupt ends idle
        if (i_wake.any_irq) begin
          state_nxt = RPM_RUN;
          lp_clear = 1'b1;
        end
      end
      RPM_PD: begin
        // only the four listed sources can wake
        if (|ext_low) begin
          state_nxt = RPM_PD_EXT;
          held_nxt = ext_low;
        end else if (i_wake.kbd_irq) begin
          state_nxt = RPM_PD_KBD;
        end else if (i_wake.usb_irq) begin
          state_nxt = RPM_RUN;
          lp_clear = 1'b1;
        end
      end
      RPM_PD_EXT: begin
        // first released pin completes the exit
        held_nxt = held_r | ext_low;
        if (|ext_rel) begin
          state_nxt = RPM_RUN;
          held_nxt = 2'h0;
          lp_clear = 1'b1;
        end
      end
      RPM_PD_KBD: begin
        // resume only after the keyboard delay
        if (kbd_done) begin
          state_nxt = RPM_RUN;
          lp_clear = 1'b1;
        end
      end
      default: begin
        // illegal code recovers to run
        state_nxt = RPM_RUN;
        held_nxt = 2'h0;
      end
    endcase
  end

  // mode-derived controls, decided from the next state
  wire nxt_run = (state_nxt == RPM_RUN);
  wire nxt_idle = (state_nxt == RPM_IDLE);
  wire nxt_pd = (state_nxt == RPM_PD);
  wire nxt_wake = (state_nxt == RPM_PD_EXT) || (state_nxt == RPM_PD_KBD);

  logic cpu_en_r;  // cpu clock enable
  logic periph_en_r;  // peripheral clock enable
  logic osc_en_r;  // oscillator enable
  logic hold_r;  // ports frozen
  logic strobe_lvl_r;  // level held on the strobes
  logic p0_low_r;  // port zero open-drain style
  logic exit_r;  // interrupt exit pulse
  logic ser_top_r;  // serial control top bit view

  // state and output registers; reset exits to run
  // next reset value included so the cpu clock stops on the edge reset rises
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || sys_rst_r || sys_rst_nxt) begin
      state_r <= RPM_RUN;
      held_r <= 2'h0;
      cpu_en_r <= 1'b0;
      periph_en_r <= 1'b0;
      osc_en_r <= 1'b1;
      hold_r <= 1'b0;
      strobe_lvl_r <= 1'b1;
      p0_low_r <= 1'b0;
      exit_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      held_r <= held_nxt;
      cpu_en_r <= nxt_run;
      periph_en_r <= nxt_run || nxt_idle;
      osc_en_r <= !nxt_pd;
      hold_r <= !nxt_run;
      strobe_lvl_r <= !(nxt_pd || nxt_wake);
      p0_low_r <= !nxt_run;
      exit_r <= lp_clear;
    end
  end

  // serial top bit selection follows the select field
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ser_top_r <= 1'b0;
    end else begin
      ser_top_r <= power_control_r[`RPM_FE_SEL_BIT] ? i_framing_error_bit : i_serial_mode_high_bit;
    end
  end

  // ---------------- outputs ----------------

  assign o_sfr_rdata = rdata_q;
  assign o_serial_ctl_top_bit = ser_top_r;
  assign o_baud_doubler = power_control_r[`RPM_BAUD_DBL_BIT];
  assign o_sys_rst = sys_rst_r;
  assign o_rst_pin_n_out = pin_out_r;
  assign o_rst_pin_n_oe = pin_oe_r;
  assign o_cpu_clk_en = cpu_en_r;
  assign o_periph_clk_en = periph_en_r;
  assign o_osc_en = osc_en_r;
  assign o_port_hold = hold_r;
  assign o_strobe_hold = hold_r;
  assign o_strobe_level = strobe_lvl_r;
  assign o_port0_low_only = p0_low_r;
  assign o_lp_exit = exit_r;

endmodule

// File: dv/rpm_monitor.sv
`timescale 1ns/1ps
// port-level checks of reset sequencing and sleep modes
module rpm_monitor
  import rpm_pkg::*;
#(
  parameter int POR_CYCLES = 1024,
  parameter int WDOG_PULSE_CYCLES = 96
) (
  // clock and block reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // inputs of the block
  input wire rpm_rst_src_t i_rst_src,
  input wire rpm_sfr_req_t i_sfr,
  // outputs of the block
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_baud_doubler,
  input wire logic o_sys_rst,
  input wire logic o_rst_pin_n_oe,
  input wire logic o_cpu_clk_en,
  input wire logic o_periph_clk_en,
  input wire logic o_osc_en,
  input wire logic o_strobe_hold,
  input wire logic o_strobe_level,
  input wire logic o_port0_low_only,
  input wire logic o_lp_exit
);
  logic [7:0] pulse_cnt_r; // cycles the pin has been pulled low
  logic [10:0] good_cnt_r; // cycles with supply and clock good
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // length of the current pin pulse
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !o_rst_pin_n_oe) begin
      pulse_cnt_r <= 8'h00;
    end else begin
      pulse_cnt_r <= pulse_cnt_r + 8'h01;
    end
  end
  // saturating run of good supply cycles
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !(i_rst_src.supply_ok && i_rst_src.osc_ok)) begin
      good_cnt_r <= 11'h000;
    end else if (good_cnt_r != 11'h7FF) begin
      good_cnt_r <= good_cnt_r + 11'h001;
    end
  end
  // accepted write to the power control register
  sequence s_wr;
    i_sfr.wr && i_sfr.addr == 8'h87 && !o_sys_rst;
  endsequence
  // oscillator gated off
  sequence s_pd;
    !o_osc_en;
  endsequence
  property p_wd_len; $fell(o_rst_pin_n_oe) |-> int'(pulse_cnt_r) == WDOG_PULSE_CYCLES; endproperty
  a_wd_len: assert property (p_wd_len) else $error("pin pulse length");
  property p_wd_go; i_rst_src.hw_wdog_ovf && !o_rst_pin_n_oe |-> ##[1:2] o_rst_pin_n_oe; endproperty
  a_wd_go: assert property (p_wd_go) else $error("pin pulse missing");
  property p_sup; !i_rst_src.supply_ok |=> o_sys_rst; endproperty
  a_sup: assert property (p_sup) else $error("supply loss no reset");
  property p_src; i_rst_src.ca_wdog_rst || !i_rst_src.rst_pin_n || i_rst_src.hw_wdog_ovf |-> ##[1:2] o_sys_rst;
  endproperty
  a_src: assert property (p_src) else $error("source no reset");
  property p_por; $fell(o_sys_rst) |-> int'(good_cnt_r) >= POR_CYCLES; endproperty
  a_por: assert property (p_por) else $error("reset released early");
  property p_rsvd; i_sfr.rd |=> !o_sfr_rdata[5]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_baud; s_wr |=> o_baud_doubler == $past(i_sfr.wdata[7]); endproperty
  a_baud: assert property (p_baud) else $error("baud bit wrong");
  property p_idle; o_strobe_hold && o_strobe_level |-> !o_cpu_clk_en && o_periph_clk_en; endproperty
  a_idle: assert property (p_idle) else $error("idle gating wrong");
  property p_pd; s_pd |-> !o_cpu_clk_en && o_port0_low_only && !o_strobe_level; endproperty
  a_pd: assert property (p_pd) else $error("deep sleep pins wrong");
  property p_exit; o_lp_exit |-> ##[0:2] o_cpu_clk_en; endproperty
  a_exit: assert property (p_exit) else $error("exit without cpu clock");
  property p_rst_cpu; o_sys_rst |-> !o_cpu_clk_en; endproperty
  a_rst_cpu: assert property (p_rst_cpu) else $error("cpu runs in reset");
endmodule
bind rpm_top rpm_monitor #(.POR_CYCLES(POR_CYCLES), .WDOG_PULSE_CYCLES(WDOG_PULSE_CYCLES)) u_mon (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_rst_src(i_rst_src), .i_sfr(i_sfr), .o_sfr_rdata(o_sfr_rdata),
  .o_baud_doubler(o_baud_doubler), .o_sys_rst(o_sys_rst), .o_rst_pin_n_oe(o_rst_pin_n_oe),
  .o_cpu_clk_en(o_cpu_clk_en), .o_periph_clk_en(o_periph_clk_en), .o_osc_en(o_osc_en),
  .o_strobe_hold(o_strobe_hold), .o_strobe_level(o_strobe_level), .o_port0_low_only(o_port0_low_only),
  .o_lp_exit(o_lp_exit));

// File: dv/rpm_far_model.sv
`timescale 1ns/1ps
// external reset network on the open-drain pin
module rpm_far_model (
  // block drive
  input wire logic i_pin_out,
  input wire logic i_pin_oe,
  // push button, active low
  input wire logic i_hold_n,
  // resolved pin level
  output logic o_pin_n
);
  // pull-up unless the block or the button pulls low
  assign o_pin_n = (i_pin_oe ? i_pin_out : 1'b1) & i_hold_n;
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
// register calls plus sleep and reset sequences
module testbench;
  import rpm_pkg::*;
  localparam int POR = 8;
  localparam int WDP = 4;
  localparam int KBD = 8;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic sup = 1'b0, ca = 1'b0, ovf = 1'b0, hold_n = 1'b1, fe = 1'b1, sm = 1'b0;
  logic pin_n, pin_out, pin_oe, top, baud, sys_rst, cpu_en, per_en, osc_en, hold, sh, sl, p0, lp_exit;
  logic [7:0] rdata;
  rpm_rst_src_t src;
  rpm_wake_t wk = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  rpm_sfr_req_t sfr = '0;
  int errors = 0;
  int cmp_count = 0;
  int n;
  assign src = '{sup, 1'b1, pin_n, ovf, ca};
  // free running clock
  always #5 i_clk = ~i_clk;
  rpm_top #(.POR_CYCLES(POR), .WDOG_PULSE_CYCLES(WDP), .KBD_WAKE_CYCLES(KBD)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_rst_src(src), .i_wake(wk), .i_sfr(sfr), .o_sfr_rdata(rdata),
    .i_framing_error_bit(fe), .i_serial_mode_high_bit(sm), .o_serial_ctl_top_bit(top),
    .o_baud_doubler(baud), .o_sys_rst(sys_rst), .o_rst_pin_n_out(pin_out), .o_rst_pin_n_oe(pin_oe),
    .o_cpu_clk_en(cpu_en), .o_periph_clk_en(per_en), .o_osc_en(osc_en), .o_port_hold(hold),
    .o_strobe_hold(sh), .o_strobe_level(sl), .o_port0_low_only(p0), .o_lp_exit(lp_exit));
  rpm_far_model far (.i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_hold_n(hold_n), .o_pin_n(pin_n));
  // compare and count
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  // one register write, then one read with compare
  task automatic wr(input logic [7:0] d);
    @(posedge i_clk);
    sfr <= '{8'h87, 1'b1, 1'b0, d};
    @(posedge i_clk);
    sfr.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    sfr <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge i_clk);
    sfr.rd <= 1'b0;
    #1;
    chk(nm, exp, rdata);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return sys_rst;
      1: return cpu_en;
      2: return osc_en;
      default: return pin_oe;
    endcase
  endfunction
  // bounded wait, n holds the cycles spent
  task automatic wait_for(input int s, input logic v);
    n = 0;
    while (sig(s) !== v && n < 300) begin
      cyc(1);
      n++;
    end
    if (n >= 300) begin
      chk("wait", 8'h01, 8'h00);
      final_report();
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    sup <= 1'b1;
    #1;
    wait_for(0, 1'b0);
    chk("por_len", 8'h01, {7'h00, n >= POR});
    rd("pof", 8'h87, 8'h10);
    $display("power up test end");
    wr(8'hEC);
    rd("fields", 8'h87, 8'hCC);
    chk("baud", 8'h01, {7'h00, baud});
    chk("fe_sel", 8'h01, {7'h00, top});
    // swap the two sources so the selection itself is seen
    @(posedge i_clk);
    fe <= 1'b0;
    sm <= 1'b1;
    wr(8'h0C);
    cyc(1);
    chk("sm_sel", 8'h01, {7'h00, top});
    chk("baud_off", 8'h00, {7'h00, baud});
    rd("unmapped", 8'h88, 8'h00);
    $display("field test end");
    wr(8'h0D);
    cyc(2);
    chk("idle", 8'h0F, {3'h0, cpu_en, per_en, sl, hold, sh});
    @(posedge i_clk);
    wk.any_irq <= 1'b1;
    #1;
    wait_for(1, 1'b1);
    chk("idle_pulse", 8'h01, {7'h00, lp_exit});
    @(posedge i_clk);
    wk.any_irq <= 1'b0;
    rd("idle_exit", 8'h87, 8'h0C);
    // user flags set too, so the reset clear is visible
    wr(8'h0D);
    @(posedge i_clk);
    hold_n <= 1'b0;
    cyc(24);
    chk("pin_rst", 8'h01, {7'h00, sys_rst});
    chk("rst_cpu", 8'h00, {7'h00, cpu_en});
    @(posedge i_clk);
    hold_n <= 1'b1;
    #1;
    wait_for(0, 1'b0);
    rd("pin_clear", 8'h87, 8'h00);
    $display("idle test end");
    // both pins enabled, both held, the second one released first
    @(posedge i_clk);
    wk.ext_zero_en <= 1'b1;
    wk.ext_one_en <= 1'b1;
    wr(8'h0E);
    cyc(2);
    chk("pd", 8'h01, {4'h0, osc_en, cpu_en, sl, p0});
    @(posedge i_clk);
    wk.any_irq <= 1'b1;
    cyc(4);
    chk("pd_any", 8'h00, {7'h00, osc_en});
    @(posedge i_clk);
    wk.any_irq <= 1'b0;
    wk.ext_irq_zero_n <= 1'b0;
    wk.ext_irq_one_n <= 1'b0;
    #1;
    wait_for(2, 1'b1);
    chk("pd_held", 8'h00, {7'h00, cpu_en});
    @(posedge i_clk);
    wk.ext_irq_one_n <= 1'b1;
    #1;
    wait_for(1, 1'b1);
    chk("pd_pulse", 8'h01, {7'h00, lp_exit});
    @(posedge i_clk);
    wk.ext_irq_zero_n <= 1'b1;
    rd("pd_exit", 8'h87, 8'h0C);
    wr(8'h07);
    cyc(2);
    chk("both", 8'h00, {6'h00, osc_en, sl});
    @(posedge i_clk);
    wk.usb_irq <= 1'b1;
    #1;
    wait_for(1, 1'b1);
    @(posedge i_clk);
    wk.usb_irq <= 1'b0;
    cyc(2);
    chk("no_idle", 8'h01, {7'h00, cpu_en});
    rd("both_clr", 8'h87, 8'h04);
    wr(8'h02);
    cyc(2);
    @(posedge i_clk);
    wk.kbd_irq <= 1'b1;
    #1;
    wait_for(1, 1'b1);
    chk("kbd_wait", 8'h01, {7'h00, n >= KBD});
    @(posedge i_clk);
    wk.kbd_irq <= 1'b0;
    $display("deep sleep test end");
    wr(8'h0C);
    // one-cycle overflow pulse
    @(posedge i_clk);
    ovf <= 1'b1;
    @(posedge i_clk);
    ovf <= 1'b0;
    #1;
    wait_for(3, 1'b1);
    chk("pin_low", 8'h00, {7'h00, pin_out});
    wait_for(3, 1'b0);
    chk("wd_len", 8'(WDP), n[7:0]);
    chk("wd_rst", 8'h01, {7'h00, sys_rst});
    wait_for(0, 1'b0);
    rd("wd_clear", 8'h87, 8'h00);
    // one-cycle supply drop
    @(posedge i_clk);
    sup <= 1'b0;
    @(posedge i_clk);
    sup <= 1'b1;
    #1;
    chk("sup_drop", 8'h01, {7'h00, sys_rst});
    wait_for(0, 1'b0);
    chk("por_again", 8'h01, {7'h00, n >= POR});
    rd("pof_again", 8'h87, 8'h10);
    // one-cycle counter-array watchdog request
    @(posedge i_clk);
    ca <= 1'b1;
    @(posedge i_clk);
    ca <= 1'b0;
    #1;
    chk("ca_rst", 8'h01, {7'h00, sys_rst});
    wait_for(0, 1'b0);
    $display("reset source test end");
    final_report();
  end
endmodule
